//--- verilog/rxsds_regs.sv
// Receive status, data and valid registers for two channels.
// Assumes a byte register port with one-cycle read and write strobes on core_clk_in.
`timescale 1ns/10ps
// Function
// RULE1: Valid flag set on holding load only when all eight bits valid.
// RULE2: Valid flags never feed the interrupt request.
// RULE3: Flow violation flag set on overflow or underflow of holding register.
// RULE4: Overflow is a load while previous byte remains unread.
// RULE5: Underflow is a host read of an empty holding register.
// RULE6: Reading status clears flow violation and end of frame of both channels.
// RULE7: End of frame after configured bit times without valid bits.
// RULE8: Full flag set whenever a byte enters the holding register.
// RULE9: Transfer on complete byte or end of frame, even if partial. A byte with no valid bit is not transferred.
// RULE10: Flags set regardless of interrupt enables, allowing polling.
// RULE11: Receive status reads zero unless receive enable is on.
// RULE12: Status register is read-only.
// RULE13: Data bit 0 is the first received bit, bit 7 the last.
// RULE14: Channel A data and valid registers are read-only.
// RULE15: Valid mask bit set means matching data bit valid.
// RULE16: Host may skip mask read when all-valid flag is set.
// RULE17: Zero end of frame length signals at first invalid bit.
// RULE18: Per-condition enables gate each channel condition onto the request.
// RULE19: Interrupt request asserted while any enabled pending flag is set.
module rxsds_regs (
    input  wire logic       core_clk_in,
    input  wire logic       reset_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_write_in,
    input  wire logic       reg_read_in,
    input  wire logic [1:0] bit_strobe_in,
    input  wire logic [1:0] bit_valid_in,
    input  wire logic [1:0] bit_data_in,
    output logic      [7:0] reg_rdata_out,
    output logic      [7:0] data_b_out,
    output logic      [7:0] valid_b_out,
    output logic            irq_out
);
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] data_a;
        logic [7:0] mask_a;
        logic [7:0] data_b;
        logic [7:0] mask_b;
        logic [1:0] unread;
        logic [1:0] over;
        logic [1:0] under;
        logic [7:0] enable;
        logic [7:0] eof_len;
        logic [7:0] mode;
        logic [7:0] rdata;
        logic       irq;
    } rxsds_regs_t;

    rxsds_regs_t st;
    rxsds_regs_t next_st;
    logic        rx_on;
    logic        rd_status;
    logic [1:0]  rd_data;

    rxsds_evt_if evt_a ();
    rxsds_evt_if evt_b ();

    assign rx_on = st.mode[rxsds_pkg::RXSDS_BIT_RX_EN];

    rxsds_chan u_chan_a (
        .core_clk_in   (core_clk_in),
        .reset_in      (reset_in),
        .rx_on_in      (rx_on),
        .bit_strobe_in (bit_strobe_in[0]),
        .bit_valid_in  (bit_valid_in[0]),
        .bit_data_in   (bit_data_in[0]),
        .eof_len_in    (st.eof_len),
        .evt           (evt_a)
    );

    rxsds_chan u_chan_b (
        .core_clk_in   (core_clk_in),
        .reset_in      (reset_in),
        .rx_on_in      (rx_on),
        .bit_strobe_in (bit_strobe_in[1]),
        .bit_valid_in  (bit_valid_in[1]),
        .bit_data_in   (bit_data_in[1]),
        .eof_len_in    (st.eof_len),
        .evt           (evt_b)
    );

    assign rd_status  = reg_read_in && reg_addr_in == rxsds_pkg::RXSDS_ADDR_STATUS;
    assign rd_data[0] = reg_read_in && reg_addr_in == rxsds_pkg::RXSDS_ADDR_DATA_A;
    assign rd_data[1] = reg_read_in && reg_addr_in == rxsds_pkg::RXSDS_ADDR_DATA_B;

    always_comb begin
        logic [1:0] load;
        logic [1:0] eof;
        logic [1:0] allv;
        logic [3:0] nib [2];
        logic [7:0] en_bits;
        logic       req;
        load    = {evt_b.load, evt_a.load};
        eof     = {evt_b.eof, evt_a.eof};
        allv    = {evt_b.all_valid, evt_a.all_valid};
        nib[0]  = st.status[3:0];
        nib[1]  = st.status[7:4];
        en_bits = st.enable;
        req     = 1'b0;
        next_st = st;

        // Control writes; status, data and valid addresses ignore writes [RULE12] [RULE14]
        if (reg_write_in) begin
            case (reg_addr_in)
                rxsds_pkg::RXSDS_ADDR_MODE: begin
                    next_st.mode = reg_wdata_in;
                end
                rxsds_pkg::RXSDS_ADDR_CONTROL: begin
                    next_st.eof_len = reg_wdata_in;
                end
                rxsds_pkg::RXSDS_ADDR_ENABLE: begin
                    next_st.enable = reg_wdata_in;
                end
                default: begin
                end
            endcase
        end

        // Clear on status read happens first so a same-cycle event still sets [RULE6]
        for (int c = 0; c < 2; c++) begin
            if (rd_status) begin
                nib[c][rxsds_pkg::RXSDS_BIT_FLOW] = 1'b0;
                nib[c][rxsds_pkg::RXSDS_BIT_EOF]  = 1'b0;
                next_st.over[c]  = 1'b0;
                next_st.under[c] = 1'b0;
            end
            if (rd_data[c]) begin
                next_st.unread[c] = 1'b0;
                // Reading an empty holding register [RULE5]
                if (!st.unread[c]) begin
                    nib[c][rxsds_pkg::RXSDS_BIT_FLOW] = 1'b1;
                    next_st.under[c] = 1'b1;
                end
            end
            if (load[c]) begin
                next_st.unread[c] = 1'b1;
                nib[c][rxsds_pkg::RXSDS_BIT_FULL]  = 1'b1;    // [RULE8]
                nib[c][rxsds_pkg::RXSDS_BIT_VALID] = allv[c]; // [RULE1] [RULE15]
                // New byte on top of an unread one [RULE4] [RULE3]
                if (st.unread[c] && !rd_data[c]) begin
                    nib[c][rxsds_pkg::RXSDS_BIT_FLOW] = 1'b1;
                    next_st.over[c] = 1'b1;
                end
            end
            if (eof[c]) begin
                nib[c][rxsds_pkg::RXSDS_BIT_EOF] = 1'b1;    // [RULE7]
            end
            if (rd_status && !load[c]) begin
                nib[c][rxsds_pkg::RXSDS_BIT_FULL] = 1'b0;
            end
        end
        if (load[0]) begin
            next_st.data_a = evt_a.data;    // [RULE13]
            next_st.mask_a = evt_a.mask;    // [RULE15]
        end
        if (load[1]) begin
            next_st.data_b = evt_b.data;
            next_st.mask_b = evt_b.mask;
        end
        // Flags set irrespective of enables, so polling works [RULE10]
        next_st.status = {nib[1], nib[0]};
        // Outside receive mode all receive status is forced to zero [RULE11]
        if (!next_st.mode[rxsds_pkg::RXSDS_BIT_RX_EN]) begin
            next_st.status = rxsds_pkg::RXSDS_RESET_BYTE;
            next_st.unread = 2'h0;
            next_st.over   = 2'h0;
            next_st.under  = 2'h0;
        end

        // Per-condition enables; the valid bits never take part [RULE18] [RULE2]
        for (int c = 0; c < 2; c++) begin
            req = req
                | (next_st.status[4*c+rxsds_pkg::RXSDS_BIT_FULL] & en_bits[4*c+rxsds_pkg::RXSDS_BIT_FULL])
                | (next_st.status[4*c+rxsds_pkg::RXSDS_BIT_EOF]  & en_bits[4*c+rxsds_pkg::RXSDS_BIT_EOF])
                | (next_st.over[c]  & en_bits[4*c+rxsds_pkg::RXSDS_EN_OVER])
                | (next_st.under[c] & en_bits[4*c+rxsds_pkg::RXSDS_EN_UNDER]);
        end
        next_st.irq = req;    // [RULE19]

        case (reg_addr_in)
            rxsds_pkg::RXSDS_ADDR_STATUS:  next_st.rdata = st.status;
            rxsds_pkg::RXSDS_ADDR_DATA_A:  next_st.rdata = st.data_a;
            rxsds_pkg::RXSDS_ADDR_VALID_A: next_st.rdata = st.mask_a;
            rxsds_pkg::RXSDS_ADDR_ENABLE:  next_st.rdata = st.enable;
            rxsds_pkg::RXSDS_ADDR_CONTROL: next_st.rdata = st.eof_len;
            rxsds_pkg::RXSDS_ADDR_MODE:    next_st.rdata = st.mode;
            default:                       next_st.rdata = rxsds_pkg::RXSDS_RESET_BYTE;
        endcase
        if (!reg_read_in) begin
            next_st.rdata = st.rdata;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata_out = st.rdata;
    assign data_b_out    = st.data_b;
    assign valid_b_out   = st.mask_b;
    assign irq_out       = st.irq;
endmodule

//--- pkg/rxsds_pkg.sv
// Package for the receive serializer_deserializer status and data registers.
// Assumes a byte-wide register port driven by the device's serial register interface.
package rxsds_pkg;
    localparam logic [7:0] RXSDS_ADDR_STATUS   = 8'h08;
    localparam logic [7:0] RXSDS_ADDR_DATA_A   = 8'h09;
    localparam logic [7:0] RXSDS_ADDR_VALID_A  = 8'h0a;
    localparam logic [7:0] RXSDS_ADDR_DATA_B   = 8'h0b;
    localparam logic [7:0] RXSDS_ADDR_ENABLE   = 8'h07;
    localparam logic [7:0] RXSDS_ADDR_CONTROL  = 8'h06;
    localparam logic [7:0] RXSDS_ADDR_MODE     = 8'h03;
    localparam int         RXSDS_BIT_FULL      = 0;
    localparam int         RXSDS_BIT_EOF       = 1;
    localparam int         RXSDS_BIT_FLOW      = 2;
    localparam int         RXSDS_BIT_VALID     = 3;
    localparam int         RXSDS_CH_B_OFFSET   = 4;
    localparam int         RXSDS_BIT_RX_EN     = 7;
    localparam int         RXSDS_BIT_TX_EN     = 6;
    localparam int         RXSDS_EN_UNDER      = 3;
    localparam int         RXSDS_EN_OVER       = 2;
    localparam logic [7:0] RXSDS_RESET_BYTE    = 8'h00;
    localparam logic [3:0] RXSDS_RESET_NIBBLE  = 4'h0;
    localparam logic [2:0] RXSDS_LAST_BIT      = 3'h7;
endpackage

//--- pkg/rxsds_evt_if.sv
// Interface carrying one channel's per-cycle events to the status logic.
// Assumes a single clock; all signals are one-cycle pulses or levels.
`timescale 1ns/10ps
interface rxsds_evt_if;
    logic       load;
    logic       all_valid;
    logic       eof;
    logic [7:0] data;
    logic [7:0] mask;
    modport src (output load, output all_valid, output eof, output data, output mask);
    modport dst (input load, input all_valid, input eof, input data, input mask);
endinterface

//--- verilog/rxsds_chan.sv
// One channel receiver: assembles bits into a byte and detects end of frame.
// Assumes bit_strobe_in marks one bit time and comes from the same clock.
`timescale 1ns/10ps
module rxsds_chan (
    input  wire logic       core_clk_in,
    input  wire logic       reset_in,
    input  wire logic       rx_on_in,
    input  wire logic       bit_strobe_in,
    input  wire logic       bit_valid_in,
    input  wire logic       bit_data_in,
    input  wire logic [7:0] eof_len_in,
    rxsds_evt_if.src        evt
);
    typedef struct packed {
        logic [7:0] shift;
        logic [7:0] vmask;
        logic [2:0] pos;
        logic       any;
        logic       started;
        logic [7:0] gap;
        logic       load;
        logic       eof;
        logic [7:0] data;
        logic [7:0] mask;
    } rxsds_chan_t;

    rxsds_chan_t st;
    rxsds_chan_t next_st;

    always_comb begin
        next_st      = st;
        next_st.load = 1'b0;
        next_st.eof  = 1'b0;
        if (!rx_on_in) begin
            next_st = '0;
        end else if (bit_strobe_in) begin
            next_st.shift[st.pos] = bit_data_in & bit_valid_in;
            next_st.vmask[st.pos] = bit_valid_in;
            next_st.any           = st.any | bit_valid_in;
            next_st.pos           = st.pos + 3'h1;
            if (bit_valid_in) begin
                next_st.started = 1'b1;
                next_st.gap     = rxsds_pkg::RXSDS_RESET_BYTE;
            end else if (st.started) begin
                next_st.gap = st.gap + 8'h01;
            end
            // Gap exceeding the length ends the frame; zero length ends at first invalid bit [RULE7] [RULE17]
            if (!bit_valid_in && st.started && st.gap >= eof_len_in) begin
                next_st.eof     = 1'b1;
                next_st.started = 1'b0;
                next_st.gap     = rxsds_pkg::RXSDS_RESET_BYTE;
            end
            // Full byte or end of frame hands the byte over, partial or not, if any of its bits is valid [RULE9]
            if (st.pos == rxsds_pkg::RXSDS_LAST_BIT || next_st.eof) begin
                next_st.load  = next_st.any;
                next_st.data  = next_st.shift;
                next_st.mask  = next_st.vmask;
                next_st.shift = rxsds_pkg::RXSDS_RESET_BYTE;
                next_st.vmask = rxsds_pkg::RXSDS_RESET_BYTE;
                next_st.pos   = 3'h0;
                next_st.any   = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign evt.load      = st.load;
    assign evt.eof       = st.eof;
    assign evt.data      = st.data;
    assign evt.mask      = st.mask;
    assign evt.all_valid = &st.mask;
endmodule

//--- dv/rxsds_props.sv
// Checker for the receive status, data and valid register block.
// Assumes it is bound to rxsds_regs and sees only its ports.
`timescale 1ns/10ps
module rxsds_props (
    input  wire logic       core_clk_in,
    input  wire logic       reset_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_write_in,
    input  wire logic       reg_read_in,
    input  wire logic [1:0] bit_strobe_in,
    input  wire logic [1:0] bit_valid_in,
    input  wire logic [1:0] bit_data_in,
    input  wire logic [7:0] reg_rdata_out,
    input  wire logic [7:0] data_b_out,
    input  wire logic [7:0] valid_b_out,
    input  wire logic       irq_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    logic [1:0] quiet;
    logic       rx_on;
    logic [7:0] ien;
    wire        q3     = quiet == 2'h3;
    wire        no_acc = !reg_read_in && !reg_write_in;
    wire        rd_st  = reg_read_in && reg_addr_in == rxsds_pkg::RXSDS_ADDR_STATUS;
    wire        wr_st  = reg_write_in && reg_addr_in == rxsds_pkg::RXSDS_ADDR_STATUS;
    wire        rd_da  = reg_read_in && reg_addr_in == rxsds_pkg::RXSDS_ADDR_DATA_A;
    wire        wr_da  = reg_write_in && reg_addr_in == rxsds_pkg::RXSDS_ADDR_DATA_A;
    wire        rd_md  = reg_read_in && reg_addr_in == rxsds_pkg::RXSDS_ADDR_MODE;
    wire        wr_md  = reg_write_in && reg_addr_in == rxsds_pkg::RXSDS_ADDR_MODE;
    // Quiet counts cycles with no bit strobe on either channel, up to 3, so no byte is still travelling towards the flags
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            quiet <= 2'h0;
            rx_on <= 1'b0;
            ien   <= 8'h00;
        end else begin
            quiet <= (bit_strobe_in != 2'h0) ? 2'h0 : (q3 ? quiet : quiet + 2'h1);
            if (wr_md) rx_on <= reg_wdata_in[rxsds_pkg::RXSDS_BIT_RX_EN];
            if (reg_write_in && reg_addr_in == rxsds_pkg::RXSDS_ADDR_ENABLE) ien <= reg_wdata_in;
        end
    end
    a_status_clear: assert property (rd_st && q3 ##1 no_acc ##1 rd_st && q3
        |=> (reg_rdata_out & 8'h77) == 8'h00) else $error("pending flags survived a status read");
    a_status_ro: assert property (rd_st && q3 ##1 no_acc ##1 wr_st && q3 ##1 no_acc ##1 rd_st && q3
        |=> (reg_rdata_out & 8'h77) == 8'h00) else $error("status write changed pending flags");
    a_rx_off_zero: assert property (rd_st && !rx_on && !$past(rx_on) |=> reg_rdata_out == 8'h00)
        else $error("status not zero with receive off");
    a_irq_gated: assert property (ien == 8'h00 && $past(ien) == 8'h00 && $past(ien, 2) == 8'h00 |-> !irq_out)
        else $error("request raised with all enables off");
    // A strobe in the read cycle itself may legally raise a fresh flag two cycles on
    a_irq_clears: assert property (rd_st && q3 && bit_strobe_in == 2'h0 ##1 no_acc |=> !irq_out)
        else $error("request stayed after status read");
    a_underflow_flag: assert property (rd_da && rx_on && q3 ##1 no_acc ##1 rd_da && q3 ##1 no_acc ##1 rd_st
        |=> reg_rdata_out[rxsds_pkg::RXSDS_BIT_FLOW]) else $error("empty data read not flagged");
    a_mode_readback: assert property (wr_md ##1 no_acc ##1 rd_md |=> reg_rdata_out == $past(reg_wdata_in, 3))
        else $error("mode register read back wrong");
    a_data_ro_kept: assert property (rd_da && q3 ##1 no_acc ##1 wr_da && q3 ##1 no_acc ##1 rd_da && q3
        |=> reg_rdata_out == $past(reg_rdata_out)) else $error("data register changed by a write");
    c_irq: cover property (irq_out);
    c_full_a: cover property (rd_st ##1 reg_rdata_out[rxsds_pkg::RXSDS_BIT_FULL]);
    c_flow_b: cover property (rd_st ##1 reg_rdata_out[6]);
endmodule
bind rxsds_regs rxsds_props i_props (.core_clk_in(core_clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .bit_strobe_in(bit_strobe_in), .bit_valid_in(bit_valid_in), .bit_data_in(bit_data_in),
    .reg_rdata_out(reg_rdata_out), .data_b_out(data_b_out), .valid_b_out(valid_b_out), .irq_out(irq_out));

//--- dv/rxsds_host.sv
// Host model: reaches the registers with one-cycle strobes.
// Assumes one access at a time; read data is taken the cycle after the strobe.
`timescale 1ns/10ps
module rxsds_host (
    input  wire logic       clk_in,
    input  wire logic [7:0] rdata_in,
    output logic      [7:0] addr_out,
    output logic      [7:0] wdata_out,
    output logic            write_out,
    output logic            read_out
);
    initial begin
        addr_out  = 8'h00;
        wdata_out = 8'h00;
        write_out = 1'b0;
        read_out  = 1'b0;
    end
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_in);
        addr_out  <= a;
        wdata_out <= d;
        write_out <= w;
        read_out  <= !w;
        @(posedge clk_in);
        write_out <= 1'b0;
        read_out  <= 1'b0;
        // Released lines show the inverse so a stale value is never mistaken for a live one
        addr_out  <= ~a;
        wdata_out <= ~d;
        @(negedge clk_in);
        q = rdata_in;
    endtask
    task automatic get_a(output logic [7:0] st, output logic [7:0] d, output logic [7:0] m);
        acc(1'b0, rxsds_pkg::RXSDS_ADDR_STATUS, 8'h00, st);
        acc(1'b0, rxsds_pkg::RXSDS_ADDR_DATA_A, 8'h00, d);
        m = 8'hff;
        if (st[rxsds_pkg::RXSDS_BIT_VALID] !== 1'b1) acc(1'b0, rxsds_pkg::RXSDS_ADDR_VALID_A, 8'h00, m);
    endtask
endmodule

//--- dv/rxsds_regs_bench.sv
// Bench for the receive status, data and valid register block.
// Assumes the host model drives the register strobes and this module the bit inputs.
`timescale 1ns/10ps
module rxsds_regs_bench;
    logic       core_clk_in = 1'b0;
    logic       reset_in    = 1'b1;
    logic [1:0] strb        = 2'h0;
    logic [1:0] vld         = 2'h0;
    logic [1:0] dat         = 2'h0;
    logic [7:0] addr, wdata, rdata, dbo, vbo, q, d, m;
    logic       wr, rd, irq;
    int         failures    = 0;
    int         n_checks    = 0;
    int         cycles      = 0;
    always #25 core_clk_in = ~core_clk_in;
    rxsds_regs i_dut (.core_clk_in(core_clk_in), .reset_in(reset_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_write_in(wr), .reg_read_in(rd), .bit_strobe_in(strb), .bit_valid_in(vld), .bit_data_in(dat),
        .reg_rdata_out(rdata), .data_b_out(dbo), .valid_b_out(vbo), .irq_out(irq));
    rxsds_host i_host (.clk_in(core_clk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
        .write_out(wr), .read_out(rd));
    task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // First bit from bit 0; strobes every other cycle, then time for the flags to land
    task automatic bits(input int c, input int n, input logic [7:0] bd, input logic [7:0] bv);
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk_in);
            strb[c] <= 1'b1;
            dat[c]  <= bd[i];
            vld[c]  <= bv[i];
            @(posedge core_clk_in);
            strb[c] <= 1'b0;
            dat[c]  <= ~bd[i];
            vld[c]  <= ~bv[i];
        end
        repeat (4) @(posedge core_clk_in);
        @(negedge core_clk_in);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        i_host.acc(1'b1, a, v, q);
    endtask
    task automatic rd_chk(input string s, input logic [7:0] a, input logic [7:0] e);
        i_host.acc(1'b0, a, 8'h00, q);
        chk(s, q, e);
    endtask
    task automatic t_byte;
        rd_chk("status", 8'h08, 8'h00);
        rd_chk("valid_a", 8'h0a, 8'h00);
        wr_reg(8'h03, 8'h80);
        rd_chk("mode", 8'h03, 8'h80);
        bits(0, 8, 8'h1e, 8'hff);
        i_host.get_a(q, d, m);
        chk("status", q, 8'h09);
        chk("data_a", d, 8'h1e);
        rd_chk("valid_a", 8'h0a, 8'hff);
        rd_chk("status", 8'h08, 8'h08);
        rd_chk("status", 8'h08, 8'h08);
    endtask
    task automatic t_eof;
        for (int n = 0; n < 4; n += 2) begin
            wr_reg(8'h06, 8'(n));
            bits(0, 3, 8'h03, 8'h07);
            bits(0, n, 8'h00, 8'h00);
            // Valid flag of the last full byte survives status reads until the next load
            rd_chk("status", 8'h08, (n == 0) ? 8'h08 : 8'h00);
            bits(0, 1, 8'h00, 8'h00);
            i_host.get_a(q, d, m);
            chk("status", q, 8'h03);
            chk("data_a", d & 8'h07, 8'h03);
            chk("valid_a", m, 8'h07);
        end
    endtask
    task automatic t_flow;
        bits(0, 8, 8'h1e, 8'hff);
        bits(0, 8, 8'h81, 8'h7f);
        rd_chk("status", 8'h08, 8'h05);
        i_host.acc(1'b0, 8'h09, 8'h00, q);
        chk("data_a", q & 8'h7f, 8'h01);
        i_host.acc(1'b0, 8'h09, 8'h00, q);
        rd_chk("status", 8'h08, 8'h04);
        rd_chk("valid_a", 8'h0a, 8'h7f);
        bits(1, 8, 8'h55, 8'hff);
        bits(1, 8, 8'h2d, 8'hff);
        chk("data_b", dbo, 8'h2d);
        chk("valid_b", vbo, 8'hff);
        rd_chk("status", 8'h08, 8'hd0);
        rd_chk("status", 8'h08, 8'h80);
    endtask
    task automatic t_irq;
        wr_reg(8'h07, 8'h01);
        bits(1, 8, 8'h2d, 8'hff);
        chk("irq", {7'h00, irq}, 8'h00);
        bits(0, 8, 8'h1e, 8'hff);
        chk("irq", {7'h00, irq}, 8'h01);
        rd_chk("status", 8'h08, 8'hd9);
        repeat (2) @(negedge core_clk_in);
        chk("irq", {7'h00, irq}, 8'h00);
        wr_reg(8'h07, 8'h77);
        rd_chk("status", 8'h08, 8'h88);
        chk("irq", {7'h00, irq}, 8'h00);
        wr_reg(8'h07, 8'h08);
        rd_chk("data_a", 8'h09, 8'h1e);
        chk("irq", {7'h00, irq}, 8'h00);
        i_host.acc(1'b0, 8'h09, 8'h00, q);
        chk("irq", {7'h00, irq}, 8'h01);
        rd_chk("status", 8'h08, 8'h8c);
        chk("irq", {7'h00, irq}, 8'h00);
        wr_reg(8'h07, 8'h00);
    endtask
    task automatic t_ro;
        rd_chk("status", 8'h08, 8'h88);
        wr_reg(8'h08, 8'hff);
        rd_chk("status", 8'h08, 8'h88);
        rd_chk("data_a", 8'h09, 8'h1e);
        wr_reg(8'h09, 8'h00);
        rd_chk("data_a", 8'h09, 8'h1e);
        wr_reg(8'h0a, 8'h00);
        rd_chk("valid_a", 8'h0a, 8'hff);
        rd_chk("unmapped", 8'h0b, 8'h00);
        wr_reg(8'h03, 8'h40);
        rd_chk("mode", 8'h03, 8'h40);
        rd_chk("status", 8'h08, 8'h00);
        bits(0, 8, 8'h1e, 8'hff);
        wr_reg(8'h03, 8'h80);
        rd_chk("status", 8'h08, 8'h00);
    endtask
    initial begin
        repeat (8) @(posedge core_clk_in);
        reset_in <= 1'b0;
        t_byte;
        t_eof;
        t_flow;
        t_irq;
        t_ro;
        end_of_test;
    end
    // Whole run needs well under a tenth of this ceiling
    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            end_of_test;
        end
    end
endmodule
